// *** rtl/vector_map_pkg.sv ***
/*
 * Constants and types shared by the interrupt vector map.
 * Assumes word-addressed program memory of at most 64K words.
 */
package vector_map_pkg;

	// =====================================================
	// Address layout
	localparam int              ADDR_W              = 16;
	localparam logic [15:0]     RESET_VECTOR_ADDR   = 16'h0000;
	localparam logic [15:0]     TABLE_START_PLAIN   = 16'h0001;
	localparam logic [15:0]     TABLE_START_OFFSET  = 16'h0002;
	localparam logic [15:0]     DEFAULT_BOOT_ADDR   = 16'h0c00;
	localparam logic [15:0]     BOOT_ADDR_LIMIT     = 16'hffc0;
	localparam int              VECTOR_STRIDE_SHIFT = 1;

	// =====================================================
	// Fuse coding
	localparam logic            FUSE_PROGRAMMED     = 1'b0;
	localparam logic            FUSE_RESET_VALUE    = 1'b1;

	// =====================================================
	// Vector numbering
	localparam int              NUM_IRQ             = 30;
	localparam int              VEC_W               = 5;
	localparam logic [4:0]      VEC_RESET           = 5'h01;
	localparam logic [4:0]      VEC_FIRST_IRQ       = 5'h02;

	// Request positions, vector number minus two
	localparam int              POS_COMPARATOR0     = 0;
	localparam int              POS_POWER_FAULT     = 4;
	localparam int              POS_POWER_CYCLE_END = 5;
	localparam int              POS_EXTERNAL0       = 6;
	localparam int              POS_WIDE_TIMER      = 10;
	localparam int              POS_NARROW_TIMER    = 14;
	localparam int              POS_CAN_MAIN        = 17;
	localparam int              POS_CAN_TIMER       = 18;
	localparam int              POS_LIN_DONE        = 19;
	localparam int              POS_LIN_ERROR       = 20;
	localparam int              POS_PIN_CHANGE0     = 21;
	localparam int              POS_SPI_DONE        = 25;
	localparam int              POS_CONVERTER_DONE  = 26;
	localparam int              POS_WATCHDOG        = 27;
	localparam int              POS_DATA_NVM_READY  = 28;
	localparam int              POS_PROG_STORE      = 29;

	// =====================================================
	// Timing
	localparam logic [1:0]      SYNC_SETTLE_CYCLES  = 2'h2;

	// =====================================================
	// Sequencer states
	typedef enum logic [3:0] {
		ST_CAPTURE    = 4'b0001,
		ST_RESET_JUMP = 4'b0010,
		ST_IDLE       = 4'b0100,
		ST_OFFER      = 4'b1000
	} map_state_type;

endpackage

// *** rtl/irq_pick_if.sv ***
/*
 * Carrier between the vector map and its priority picker.
 * Assumes both ends sit in the same clock domain.
 */
`timescale 1ns/1ps

interface irq_pick_if #(
	parameter int N = 30
);
	logic [N-1:0]         req;
	logic                 hit;
	logic [$clog2(N)-1:0] idx;

	modport source (output req, input hit, input idx);
	modport picker (input req, output hit, output idx);
endinterface

// *** rtl/irq_priority_pick.sv ***
/*
 * Fixed-priority picker: lowest request position wins.
 * Assumes requests are already masked by the caller.
 */
`timescale 1ns/1ps

module irq_priority_pick #(
	parameter int N = 30
) (
	irq_pick_if.picker pick
);

	// =====================================================
	// Checks
	if (N < 2) begin : g_bad_n
		$error("irq_priority_pick needs at least two requests");
	end

	// =====================================================
	// Search
	logic [$clog2(N)-1:0] idx_found;
	logic                 any_found;

	// Scan downward so the lowest set position is the last written [RULE15]
	always_comb begin
		idx_found = '0;
		any_found = 1'b0;
		for (int i = N - 1; i >= 0; i--) begin
			if (pick.req[i]) begin
				idx_found = ($clog2(N))'(i);
				any_found = 1'b1;
			end
		end
	end

	assign pick.hit = any_found;
	assign pick.idx = idx_found;

endmodule // irq_priority_pick

// *** rtl/interrupt_vector_map.sv ***
/*
 * Reset entry and interrupt vector address generation.
 * Assumes peripheral requests, the core control bits and the core's
 * take strobe all come from logic on clk_sys; the boot fuse is a
 * static level from outside and is synchronised before use.
 */
// Notes on behaviour
// RULE1: Any reset leads to program address zero unless the fuse redirects.
// RULE2: Comparators 0 to 3 take vectors 2 to 5 at 0x0002 to 0x0008.
// RULE3: Power stage fault and cycle end take vectors 6 and 7, else unused.
// RULE4: External requests 0 to 3 take vectors 8 to 11 at 0x000e to 0x0014.
// RULE5: Wide timer capture, match A, match B, overflow take vectors 12-15.
// RULE6: Narrow timer match A, match B and overflow take vectors 16 to 18.
// RULE7: CAN main, CAN timer, LIN done and LIN error take 0x0024 to 0x002a.
// RULE8: Pin change requests 0 to 3 take vectors 23 to 26.
// RULE9: Serial transfer done takes 0x0034, converter done takes 0x0036.
// RULE10: Watchdog, data memory ready, store ready take 0x0038 to 0x003c.
// RULE11: A programmed boot fuse starts execution at the boot reset address.
// RULE12: The boot fuse reads 1 when unprogrammed and 0 when programmed.
// RULE13: With table select set each vector moves up by the boot start.
// RULE14: Table start is boot address plus 2 when selected, else 0x001.
// RULE15: Of several pending requests the lowest vector number goes first.
`timescale 1ns/1ps

module interrupt_vector_map
	import vector_map_pkg::*;
#(
	parameter logic [15:0] BOOT_RESET_ADDR  = DEFAULT_BOOT_ADDR,
	parameter bit          HAS_POWER_STAGE  = 1'b1
) (
	input  wire logic                clk_sys,
	input  wire logic                rst,
	input  wire logic                boot_reset_fuse,
	input  wire logic                vector_table_select,
	input  wire logic                global_irq_enable,
	input  wire logic                core_irq_take,
	input  wire logic                comparator0_irq,
	input  wire logic                comparator1_irq,
	input  wire logic                comparator2_irq,
	input  wire logic                comparator3_irq,
	input  wire logic                power_stage_fault_irq,
	input  wire logic                power_stage_cycle_end_irq,
	input  wire logic                external_irq0,
	input  wire logic                external_irq1,
	input  wire logic                external_irq2,
	input  wire logic                external_irq3,
	input  wire logic                wide_timer_capture_irq,
	input  wire logic                wide_timer_match_a_irq,
	input  wire logic                wide_timer_match_b_irq,
	input  wire logic                wide_timer_overflow_irq,
	input  wire logic                narrow_timer_match_a_irq,
	input  wire logic                narrow_timer_match_b_irq,
	input  wire logic                narrow_timer_overflow_irq,
	input  wire logic                can_main_irq,
	input  wire logic                can_timer_overflow_irq,
	input  wire logic                lin_transfer_done_irq,
	input  wire logic                lin_error_irq,
	input  wire logic                pin_change_irq0,
	input  wire logic                pin_change_irq1,
	input  wire logic                pin_change_irq2,
	input  wire logic                pin_change_irq3,
	input  wire logic                spi_transfer_done_irq,
	input  wire logic                converter_done_irq,
	input  wire logic                watchdog_timeout_irq,
	input  wire logic                data_nvm_ready_irq,
	input  wire logic                program_store_ready_irq,
	output logic                     reset_branch,
	output logic [ADDR_W-1:0]        reset_entry_addr,
	output logic [ADDR_W-1:0]        vector_table_start,
	output logic                     irq_request,
	output logic [VEC_W-1:0]         irq_vector_number,
	output logic [ADDR_W-1:0]        irq_vector_addr,
	output logic [NUM_IRQ-1:0]       irq_clear,
	output logic [NUM_IRQ-1:0]       irq_pending
);

	// =====================================================
	// Elaboration checks
	if (BOOT_RESET_ADDR > BOOT_ADDR_LIMIT) begin : g_bad_boot
		$error("Boot reset address leaves no room for the table");
	end
	if (BOOT_RESET_ADDR[0] != 1'b0) begin : g_odd_boot
		$error("Boot reset address must be even");
	end

	// =====================================================
	// Request gathering
	logic [NUM_IRQ-1:0] raw_req;
	logic [NUM_IRQ-1:0] usable_mask;
	logic [NUM_IRQ-1:0] masked_req;

	assign raw_req[POS_COMPARATOR0]         = comparator0_irq;     // [RULE2]
	assign raw_req[POS_COMPARATOR0 + 1]     = comparator1_irq;     // [RULE2]
	assign raw_req[POS_COMPARATOR0 + 2]     = comparator2_irq;     // [RULE2]
	assign raw_req[POS_COMPARATOR0 + 3]     = comparator3_irq;     // [RULE2]
	assign raw_req[POS_POWER_FAULT]         = power_stage_fault_irq; // [RULE3]
	assign raw_req[POS_POWER_CYCLE_END]     =
		power_stage_cycle_end_irq;                                 // [RULE3]
	assign raw_req[POS_EXTERNAL0]           = external_irq0;       // [RULE4]
	assign raw_req[POS_EXTERNAL0 + 1]       = external_irq1;       // [RULE4]
	assign raw_req[POS_EXTERNAL0 + 2]       = external_irq2;       // [RULE4]
	assign raw_req[POS_EXTERNAL0 + 3]       = external_irq3;       // [RULE4]
	assign raw_req[POS_WIDE_TIMER]          = wide_timer_capture_irq; // [RULE5]
	assign raw_req[POS_WIDE_TIMER + 1]      = wide_timer_match_a_irq; // [RULE5]
	assign raw_req[POS_WIDE_TIMER + 2]      = wide_timer_match_b_irq; // [RULE5]
	assign raw_req[POS_WIDE_TIMER + 3]      = wide_timer_overflow_irq; // [RULE5]
	assign raw_req[POS_NARROW_TIMER]        = narrow_timer_match_a_irq; // [RULE6]
	assign raw_req[POS_NARROW_TIMER + 1]    = narrow_timer_match_b_irq; // [RULE6]
	assign raw_req[POS_NARROW_TIMER + 2]    =
		narrow_timer_overflow_irq;                                 // [RULE6]
	assign raw_req[POS_CAN_MAIN]            = can_main_irq;        // [RULE7]
	assign raw_req[POS_CAN_TIMER]           = can_timer_overflow_irq; // [RULE7]
	assign raw_req[POS_LIN_DONE]            = lin_transfer_done_irq; // [RULE7]
	assign raw_req[POS_LIN_ERROR]           = lin_error_irq;       // [RULE7]
	assign raw_req[POS_PIN_CHANGE0]         = pin_change_irq0;     // [RULE8]
	assign raw_req[POS_PIN_CHANGE0 + 1]     = pin_change_irq1;     // [RULE8]
	assign raw_req[POS_PIN_CHANGE0 + 2]     = pin_change_irq2;     // [RULE8]
	assign raw_req[POS_PIN_CHANGE0 + 3]     = pin_change_irq3;     // [RULE8]
	assign raw_req[POS_SPI_DONE]            = spi_transfer_done_irq; // [RULE9]
	assign raw_req[POS_CONVERTER_DONE]      = converter_done_irq;  // [RULE9]
	assign raw_req[POS_WATCHDOG]            = watchdog_timeout_irq; // [RULE10]
	assign raw_req[POS_DATA_NVM_READY]      = data_nvm_ready_irq;  // [RULE10]
	assign raw_req[POS_PROG_STORE]          = program_store_ready_irq; // [RULE10]

	// Variants without the power stage never raise vectors 6 and 7
	always_comb begin
		usable_mask = '1;
		if (!HAS_POWER_STAGE) begin
			usable_mask[POS_POWER_FAULT]     = 1'b0;  // [RULE3]
			usable_mask[POS_POWER_CYCLE_END] = 1'b0;  // [RULE3]
		end
	end

	assign masked_req = raw_req & usable_mask & {NUM_IRQ{global_irq_enable}};

	// =====================================================
	// State registers, read by the logic below
	logic                       fuse_sync1_reg;
	logic                       fuse_sync2_reg;
	map_state_type              state_reg;
	map_state_type              state_next;
	logic [VEC_W-1:0]           vec_no_reg;
	logic [VEC_W-1:0]           vec_no_next;
	logic [NUM_IRQ-1:0]         irq_clear_reg;
	logic [NUM_IRQ-1:0]         irq_clear_next;
	logic [ADDR_W-1:0]          reset_addr_reg;
	logic [ADDR_W-1:0]          reset_addr_next;

	// =====================================================
	// Priority pick
	irq_pick_if #(.N(NUM_IRQ)) pick_bus ();

	// Hold off new picks while a clear pulse is still on its way out
	logic clear_busy;

	assign clear_busy   = |irq_clear_reg;
	assign pick_bus.req = masked_req;

	irq_priority_pick #(
		.N    (NUM_IRQ)
	) u_pick (
		.pick (pick_bus.picker)
	);

	// =====================================================
	// Address arithmetic
	logic [ADDR_W-1:0] boot_base;
	logic [VEC_W-1:0]  pick_vec_no;
	logic [ADDR_W-1:0] held_norm_addr;
	logic [ADDR_W-1:0] held_addr;
	logic [ADDR_W-1:0] table_start;
	logic [ADDR_W-1:0] boot_entry;

	assign boot_base   = BOOT_RESET_ADDR;
	assign pick_vec_no = VEC_W'(pick_bus.idx) + VEC_FIRST_IRQ;

	// Vector n sits at word 2*(n-1) of the table
	assign held_norm_addr =
		ADDR_W'(vec_no_reg - VEC_RESET) << VECTOR_STRIDE_SHIFT;

	// Relocation follows the select bit live, even mid-offer [RULE13]
	assign held_addr = vector_table_select ?
		ADDR_W'(held_norm_addr + boot_base) : held_norm_addr;

	// Table start does not depend on the fuse [RULE14]
	assign table_start = vector_table_select ?
		ADDR_W'(boot_base + TABLE_START_OFFSET) : TABLE_START_PLAIN;

	// Zero means programmed [RULE12]
	assign boot_entry = (fuse_sync2_reg == FUSE_PROGRAMMED) ?
		boot_base : RESET_VECTOR_ADDR;                         // [RULE11]

	// =====================================================
	// Fuse synchroniser
	logic [1:0] settle_reg;
	logic [1:0] settle_next;
	logic       settle_done;

	assign settle_done = (settle_reg == SYNC_SETTLE_CYCLES);
	assign settle_next = settle_done ? settle_reg : 2'(settle_reg + 2'h1);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			fuse_sync1_reg <= FUSE_RESET_VALUE;
			fuse_sync2_reg <= FUSE_RESET_VALUE;
			settle_reg     <= 2'h0;
		end else begin
			fuse_sync1_reg <= boot_reset_fuse;
			fuse_sync2_reg <= fuse_sync1_reg;
			settle_reg     <= settle_next;
		end
	end

	// =====================================================
	// Sequencer
	logic                    held_still_req;
	logic [$clog2(NUM_IRQ)-1:0] held_pos;

	assign held_pos       = ($clog2(NUM_IRQ))'(vec_no_reg - VEC_FIRST_IRQ);
	assign held_still_req = masked_req[held_pos];

	always_comb begin
		state_next      = state_reg;
		vec_no_next     = vec_no_reg;
		irq_clear_next  = '0;
		reset_addr_next = reset_addr_reg;
		case (state_reg)
			ST_CAPTURE: begin
				if (settle_done) begin
					reset_addr_next = boot_entry;      // [RULE1] [RULE11]
					state_next      = ST_RESET_JUMP;
				end
			end
			ST_RESET_JUMP: begin
				state_next = ST_IDLE;
			end
			ST_IDLE: begin
				if (pick_bus.hit && !clear_busy) begin
					vec_no_next = pick_vec_no;              // [RULE15]
					state_next  = ST_OFFER;
				end
			end
			ST_OFFER: begin
				if (core_irq_take) begin
					irq_clear_next[held_pos] = 1'b1;
					state_next               = ST_IDLE;
				end else if (!held_still_req) begin
					// Source withdrew; rearbitrate rather than offer a dead one
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_CAPTURE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_reg      <= ST_CAPTURE;
			vec_no_reg     <= VEC_FIRST_IRQ;
			irq_clear_reg  <= '0;
			reset_addr_reg <= RESET_VECTOR_ADDR;               // [RULE1]
		end else begin
			state_reg      <= state_next;
			vec_no_reg     <= vec_no_next;
			irq_clear_reg  <= irq_clear_next;
			reset_addr_reg <= reset_addr_next;
		end
	end

	// =====================================================
	// Registered data outputs
	logic [ADDR_W-1:0]  vec_addr_reg;
	logic [ADDR_W-1:0]  table_start_reg;
	logic [NUM_IRQ-1:0] pending_reg;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			vec_addr_reg    <= RESET_VECTOR_ADDR;
			table_start_reg <= TABLE_START_PLAIN;
			pending_reg     <= '0;
		end else begin
			vec_addr_reg    <= held_addr;                      // [RULE13]
			table_start_reg <= table_start;                    // [RULE14]
			pending_reg     <= masked_req;
		end
	end

	// =====================================================
	// Port drive
	assign reset_branch       = (state_reg == ST_RESET_JUMP);
	assign reset_entry_addr   = reset_addr_reg;
	assign vector_table_start = table_start_reg;
	// Address trails the number by one edge; the core reads it later
	assign irq_request        = (state_reg == ST_OFFER);
	assign irq_vector_number  = vec_no_reg;
	assign irq_vector_addr    = vec_addr_reg;
	assign irq_clear          = irq_clear_reg;
	assign irq_pending        = pending_reg;

endmodule // interrupt_vector_map

// *** tb/interrupt_vector_map_chk.sv ***
/*
 * Concurrent checks on the ports of the interrupt vector map.
 * Assumes one clock domain and a boot fuse held static around reset.
 */
`timescale 1ns/1ps

module interrupt_vector_map_chk
	import vector_map_pkg::*;
#(
	parameter logic [15:0] BOOT_RESET_ADDR = DEFAULT_BOOT_ADDR
) (
	input wire logic                clk_sys,
	input wire logic                rst,
	input wire logic                boot_reset_fuse,
	input wire logic                vector_table_select,
	input wire logic                global_irq_enable,
	input wire logic                core_irq_take,
	input wire logic                reset_branch,
	input wire logic [ADDR_W-1:0]   reset_entry_addr,
	input wire logic [ADDR_W-1:0]   vector_table_start,
	input wire logic                irq_request,
	input wire logic [VEC_W-1:0]    irq_vector_number,
	input wire logic [ADDR_W-1:0]   irq_vector_addr,
	input wire logic [NUM_IRQ-1:0]  irq_clear,
	input wire logic [NUM_IRQ-1:0]  irq_pending
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// =====================================================
	// Reset entry
	AST_RELEASE_BRANCH: assert property ($fell(rst) |-> ##[1:5] reset_branch)
		else $error("no reset branch after release");
	AST_BRANCH_PULSE: assert property (reset_branch |=> !reset_branch)
		else $error("reset branch longer than one cycle");
	AST_ENTRY_ADDR: assert property (reset_branch |-> reset_entry_addr ==
		(boot_reset_fuse == FUSE_PROGRAMMED ? BOOT_RESET_ADDR : RESET_VECTOR_ADDR))
		else $error("wrong reset entry address");

	// =====================================================
	// Vector table
	AST_TABLE_START: assert property (!$past(rst) |-> vector_table_start ==
		($past(vector_table_select) ? BOOT_RESET_ADDR + TABLE_START_OFFSET
		: TABLE_START_PLAIN)) else $error("wrong table start");
	// Address lags the number by one cycle, so judge it against the past
	AST_VECTOR_ADDR: assert property (irq_request && $past(irq_request) |->
		irq_vector_addr == ((16'($past(irq_vector_number)) - 16'h1) << 1)
		+ ($past(vector_table_select) ? BOOT_RESET_ADDR : 16'h0))
		else $error("vector address does not match number");
	AST_CLEAR_MAP: assert property (irq_request && core_irq_take |=>
		!irq_request && irq_clear == (30'h1 << ($past(irq_vector_number) - 5'h2)))
		else $error("taken vector cleared the wrong source");

	// =====================================================
	// Arbitration
	// A source just cleared may still show pending for one cycle
	AST_LOWEST_WINS: assert property ($rose(irq_request) |->
		(irq_pending & ~$past(irq_clear)
		& ((30'h1 << (irq_vector_number - 5'h2)) - 30'h1)) == '0)
		else $error("offered vector is not the lowest pending");
	AST_OFFER_HOLD: assert property (irq_request && $past(irq_request)
		&& !$past(core_irq_take) |-> $stable(irq_vector_number))
		else $error("offered number changed during offer");
	AST_MASKED: assert property (!global_irq_enable |=> irq_pending == '0)
		else $error("pending shown while globally masked");

	COV_BRANCH: cover property (reset_branch);
	COV_TAKE_MOVED: cover property (core_irq_take && vector_table_select);
	COV_CONTEST: cover property ($rose(irq_request) && $countones(irq_pending) > 1);
endmodule // interrupt_vector_map_chk

bind interrupt_vector_map interrupt_vector_map_chk #(
	.BOOT_RESET_ADDR(BOOT_RESET_ADDR)
) i_interrupt_vector_map_chk (.clk_sys, .rst, .boot_reset_fuse,
	.vector_table_select, .global_irq_enable, .core_irq_take, .reset_branch,
	.reset_entry_addr, .vector_table_start, .irq_request, .irq_vector_number,
	.irq_vector_addr, .irq_clear, .irq_pending);

// *** tb/irq_far_side.sv ***
/*
 * Far-side model: peripheral request latches and the core's take logic.
 * Assumes raise is a one-cycle pulse per source driven on clk_sys.
 */
`timescale 1ns/1ps

module irq_far_side
	import vector_map_pkg::*;
(
	input  wire logic                clk_sys,
	input  wire logic                rst,
	input  wire logic [NUM_IRQ-1:0]  raise,
	input  wire logic                slow,
	input  wire logic                irq_request,
	input  wire logic [NUM_IRQ-1:0]  irq_clear,
	output logic      [NUM_IRQ-1:0]  src,
	output logic                     core_irq_take
);
	logic [2:0] wait_cnt;

	// =====================================================
	// Sources and core
	// Flags drop on the edge that ends the clear pulse, not earlier
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			src           <= '0;
			core_irq_take <= 1'b0;
			wait_cnt      <= 3'h0;
		end else begin
			src           <= (src & ~irq_clear) | raise;
			core_irq_take <= irq_request && !core_irq_take
				&& wait_cnt >= (slow ? 3'h3 : 3'h0);
			wait_cnt      <= (irq_request && !core_irq_take) ? wait_cnt + 3'h1 : 3'h0;
		end
	end
endmodule // irq_far_side

// *** tb/interrupt_vector_map_bench.sv ***
/*
 * Self-checking bench for the interrupt vector map.
 * Assumes the far-side model answers offers; bench samples on negedge.
 */
`timescale 1ns/1ps

`define CHECK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
	n_mismatch++; $display("FAIL %s expected %0h seen %0h", nm, ex, got); end end

module interrupt_vector_map_bench;
	import vector_map_pkg::*;
	// Off the default so a hard-wired base shows up
	localparam logic [15:0] BOOT = 16'h1e00;

	logic                clk_sys, rst, boot_reset_fuse, vector_table_select;
	logic                global_irq_enable, core_irq_take, slow;
	logic                reset_branch, irq_request;
	logic                lite_req;
	logic [ADDR_W-1:0]   reset_entry_addr, vector_table_start, irq_vector_addr;
	logic [VEC_W-1:0]    irq_vector_number;
	logic [NUM_IRQ-1:0]  raise, s, irq_clear, irq_pending;
	int                  n_mismatch = 0;
	int                  tests_run = 0;

	// =====================================================
	// Instances
	irq_far_side i_irq_far_side (.clk_sys, .rst, .raise, .slow, .irq_request,
		.irq_clear, .src(s), .core_irq_take);
	interrupt_vector_map #(.BOOT_RESET_ADDR(BOOT)) i_interrupt_vector_map (
		.clk_sys, .rst, .boot_reset_fuse, .vector_table_select,
		.global_irq_enable, .core_irq_take, .reset_branch, .reset_entry_addr,
		.vector_table_start, .irq_request, .irq_vector_number, .irq_vector_addr,
		.irq_clear, .irq_pending,
		.comparator0_irq(s[0]), .comparator1_irq(s[1]), .comparator2_irq(s[2]),
		.comparator3_irq(s[3]), .power_stage_fault_irq(s[4]),
		.power_stage_cycle_end_irq(s[5]), .external_irq0(s[6]),
		.external_irq1(s[7]), .external_irq2(s[8]), .external_irq3(s[9]),
		.wide_timer_capture_irq(s[10]), .wide_timer_match_a_irq(s[11]),
		.wide_timer_match_b_irq(s[12]), .wide_timer_overflow_irq(s[13]),
		.narrow_timer_match_a_irq(s[14]), .narrow_timer_match_b_irq(s[15]),
		.narrow_timer_overflow_irq(s[16]), .can_main_irq(s[17]),
		.can_timer_overflow_irq(s[18]), .lin_transfer_done_irq(s[19]),
		.lin_error_irq(s[20]), .pin_change_irq0(s[21]), .pin_change_irq1(s[22]),
		.pin_change_irq2(s[23]), .pin_change_irq3(s[24]),
		.spi_transfer_done_irq(s[25]), .converter_done_irq(s[26]),
		.watchdog_timeout_irq(s[27]), .data_nvm_ready_irq(s[28]),
		.program_store_ready_irq(s[29]));
	// No power stage here; vectors 6 and 7 must never be offered
	// Shares the core take with the main copy; both stay in step only while they offer the same vector
	interrupt_vector_map #(.BOOT_RESET_ADDR(BOOT), .HAS_POWER_STAGE(1'b0))
		i_interrupt_vector_map_lite (
		.clk_sys, .rst, .boot_reset_fuse, .vector_table_select,
		.global_irq_enable, .core_irq_take, .reset_branch(),
		.reset_entry_addr(), .vector_table_start(), .irq_request(lite_req),
		.irq_vector_number(), .irq_vector_addr(), .irq_clear(),
		.irq_pending(),
		.comparator0_irq(s[0]), .comparator1_irq(s[1]), .comparator2_irq(s[2]),
		.comparator3_irq(s[3]), .power_stage_fault_irq(s[4]),
		.power_stage_cycle_end_irq(s[5]), .external_irq0(s[6]),
		.external_irq1(s[7]), .external_irq2(s[8]), .external_irq3(s[9]),
		.wide_timer_capture_irq(s[10]), .wide_timer_match_a_irq(s[11]),
		.wide_timer_match_b_irq(s[12]), .wide_timer_overflow_irq(s[13]),
		.narrow_timer_match_a_irq(s[14]), .narrow_timer_match_b_irq(s[15]),
		.narrow_timer_overflow_irq(s[16]), .can_main_irq(s[17]),
		.can_timer_overflow_irq(s[18]), .lin_transfer_done_irq(s[19]),
		.lin_error_irq(s[20]), .pin_change_irq0(s[21]), .pin_change_irq1(s[22]),
		.pin_change_irq2(s[23]), .pin_change_irq3(s[24]),
		.spi_transfer_done_irq(s[25]), .converter_done_irq(s[26]),
		.watchdog_timeout_irq(s[27]), .data_nvm_ready_irq(s[28]),
		.program_store_ready_irq(s[29]));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// =====================================================
	// Helpers
	task automatic summarize;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// 0 offer, 1 clear pulse, 2 reset branch
	task automatic wait_sig(input int which);
		int k;
		for (k = 0; k < 40; k++) begin
			@(negedge clk_sys);
			if (which == 0 && irq_request === 1'b1) break;
			if (which == 1 && |irq_clear === 1'b1) break;
			if (which == 2 && reset_branch === 1'b1) break;
		end
		if (k == 40) begin
			n_mismatch++;
			$display("FAIL wait %0d expected 1 seen 0", which);
			summarize();
		end
	endtask

	task automatic pulse_src(input logic [NUM_IRQ-1:0] v);
		@(posedge clk_sys);
		raise <= v;
		@(posedge clk_sys);
		raise <= '0;
	endtask

	// =====================================================
	// Scenarios
	task automatic test_reset(input logic fuse);
		@(posedge clk_sys);
		rst <= 1'b1;
		boot_reset_fuse <= fuse;
		vector_table_select <= 1'b0;
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		wait_sig(2);
		`CHECK("entry", fuse ? RESET_VECTOR_ADDR : BOOT, reset_entry_addr)
		`CHECK("start", TABLE_START_PLAIN, vector_table_start)
		$display("test reset fuse %0b done", fuse);
	endtask

	task automatic test_vectors(input logic sel, input logic slw);
		@(posedge clk_sys);
		vector_table_select <= sel;
		slow <= slw;
		repeat (3) @(negedge clk_sys);
		`CHECK("start", sel ? BOOT + 16'h2 : 16'h1, vector_table_start)
		for (int n = 0; n < NUM_IRQ; n++) begin
			pulse_src(30'h1 << n);
			wait_sig(0);
			`CHECK("number", 5'(n + 2), irq_vector_number)
			`CHECK("pending", 30'h1 << n, irq_pending)
			`CHECK("lite", (n != 4 && n != 5), lite_req)
			@(negedge clk_sys);
			`CHECK("addr", 16'(2 * n + 2) + (sel ? BOOT : 16'h0), irq_vector_addr)
			wait_sig(1);
			`CHECK("clear", 30'h1 << n, irq_clear)
		end
		$display("test vectors select %0b done", sel);
	endtask

	task automatic test_priority;
		logic [4:0] exp_vec [3] = '{5'h07, 5'h0e, 5'h1d};
		pulse_src((30'h1 << 27) | (30'h1 << 12) | (30'h1 << 5));
		foreach (exp_vec[i]) begin
			wait_sig(0);
			`CHECK("order", exp_vec[i], irq_vector_number)
			wait_sig(1);
		end
		$display("test priority done");
	endtask

	task automatic test_mask;
		@(posedge clk_sys);
		global_irq_enable <= 1'b0;
		pulse_src(30'h1 << 3);
		repeat (10) @(negedge clk_sys);
		`CHECK("masked req", 1'b0, irq_request)
		`CHECK("masked pend", 30'h0, irq_pending)
		@(posedge clk_sys);
		global_irq_enable <= 1'b1;
		wait_sig(0);
		`CHECK("unmasked", 5'h05, irq_vector_number)
		wait_sig(1);
		$display("test mask done");
	endtask

	initial begin
		rst = 1'b1;
		boot_reset_fuse = 1'b1;
		vector_table_select = 1'b0;
		global_irq_enable = 1'b1;
		slow = 1'b0;
		raise = '0;
		test_reset(1'b1);
		test_vectors(1'b0, 1'b0);
		test_vectors(1'b1, 1'b1);
		test_priority();
		test_mask();
		test_reset(1'b0);
		summarize();
	end
endmodule // interrupt_vector_map_bench
